/* File: hw/lbc_pkg.sv */
// package: constants and types for loopback and inband code control
package lbc_pkg;
    localparam int NCH = 4; // channels
    // register offsets, 5-bit address space
    localparam logic [4:0] ADR_DLOOP = 5'h00; // digital_loop_reg
    localparam logic [4:0] ADR_ALOOP = 5'h01; // analog_loop_reg
    localparam logic [4:0] ADR_RLOOP = 5'h02; // remote_loop_reg
    localparam logic [4:0] ADR_TAO = 5'h03; // all_ones_transmit_reg
    localparam logic [4:0] ADR_AUTO_ALL_ONES_ON_LOSS = 5'h04; // auto_all_ones_on_loss
    localparam logic [4:0] ADR_GCF = 5'h05; // global_config_reg
    localparam logic [4:0] ADR_LOSS = 5'h06; // loss status, read only
    localparam logic [4:0] ADR_CFG = 5'h08; // inband_code_config
    localparam logic [4:0] ADR_ACTP = 5'h09; // activate_code_pattern
    localparam logic [4:0] ADR_DEAP = 5'h0a; // deactivate_code_pattern
    localparam logic [4:0] ADR_STAT = 5'h0b; // inband_code_status
    localparam logic [4:0] ADR_ISTAT = 5'h0c; // inband_code_irq_status
    localparam logic [4:0] ADR_IMASK = 5'h0d; // inband_code_irq_mask
    localparam logic [4:0] ADR_GSEL = 5'h0e; // code_generator_select
    localparam logic [4:0] ADR_GEN = 5'h0f; // code_generator_enable
    // field positions
    localparam int GCF_ALARM_INSERT_ENABLE = 0; // alarm_insert_enable
    localparam int CFG_DET = 0; // code_detect_enable
    localparam int CFG_AUTO = 1; // auto_loop_action_enable
    localparam int CFG_ALEN = 2; // activate_code_length lsb
    localparam int CFG_DLEN = 4; // deactivate_code_length lsb
    localparam logic [7:0] REG_RST = 8'h00; // reset of every register
    localparam logic [3:0] LEN_BASE = 4'h5; // code length for field 0
    // timing
    localparam int ALL_ONES_TRANSMIT_MODE_HOLD_CYC = 16; // mclk cycles of held tx clock
    localparam int CLK_KHZ = 25000; // mclk rate
    localparam int LOOP_TIME_MS = 5100; // continuous code time
    localparam int LOOP_CYC = LOOP_TIME_MS * CLK_KHZ; // cycles in 5.1 s
    localparam int BIT_DIV = 12; // mclk cycles per line bit
    localparam int LOS_ZEROS = 32; // zeros that mean loss of signal
    localparam logic [4:0] CODE_MIN_BITS = 5'h10; // bits to call code
    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } lbc_req_t;
    // one receive word, a bit per channel
    typedef struct packed {
        logic [NCH-1:0] receive_data_pos_out;
        logic [NCH-1:0] violation_or_neg_out;
    } lbc_rx_t;
    // code seen on a channel
    typedef enum logic [1:0] {LBC_NONE, LBC_ACT, LBC_DEACT} lbc_code_t;
endpackage

/* File: hw/lbc_top.sv */
// loopback, all-ones and inband code control with receive fifo
`timescale 1ns/10ps
`default_nettype none

// fifo for receive words, parameterised width and depth
module lbc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH]; // storage
    logic [AW:0] wp_q, wp_d, rp_q, rp_d; // pointers with wrap bit
    logic full, empty;

    // flags from pointers
    assign empty = (wp_q == rp_q);
    assign full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_q[rp_q[AW-1:0]];

    // pointer advance
    always_comb begin
        wp_d = wp_q + (AW+1)'(in_valid && !full);
        rp_d = rp_q + (AW+1)'(out_ready && !empty);
    end

    // pointers and storage
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (in_valid && !full) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule

// How it works
// - registers or strap pins select loopback modes
// - digital loop sends tx data to receive
// - loss still watched; ais and all-ones apply
// - analog loop feeds line bit back inside
// - remote loop sends line data back out
// - both bits set give dual loopback
// - in hw mode, tx clock high past 16 cycles: all ones
// - all-ones by register or on loss
// - all-ones rate comes from mclk divider
// - activate code for 5.1 s enters remote
// - deactivate code for 5.1 s leaves remote
// - config bits enable detect and auto action
// - two-bit lengths, separate pattern registers
// - code settings shared by all channels
// - status change latches masked interrupt
// - select picks code, enable starts sending
// - status read clears latched interrupt bits
// - mask resets zero, ignoring changes
module lbc_top #(
    parameter int BIT_DIV = lbc_pkg::BIT_DIV,
    parameter int unsigned LOOP_CYC = lbc_pkg::LOOP_CYC,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire lbc_pkg::lbc_req_t reg_req,
    output logic [7:0] reg_rdata,
    // strap pins
    input wire logic hw_mode,
    input wire logic [lbc_pkg::NCH-1:0] loop_select_pin,
    input wire logic [lbc_pkg::NCH-1:0] loop_select_act,
    // system transmit side
    input wire logic [lbc_pkg::NCH-1:0] transmit_clock_in,
    input wire logic [lbc_pkg::NCH-1:0] transmit_data_pos_in,
    // line side
    input wire logic [lbc_pkg::NCH-1:0] line_rx_tip,
    input wire logic [lbc_pkg::NCH-1:0] line_rx_ring,
    output logic [lbc_pkg::NCH-1:0] line_tx_tip,
    output logic [lbc_pkg::NCH-1:0] line_tx_ring,
    // receive stream
    output lbc_pkg::lbc_rx_t rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    // interrupt
    output logic irq_n
);
    import lbc_pkg::*;
    localparam int PW = 1 + 6 * NCH;

    logic [PW-1:0] s1_q, s2_q; // pin synchroniser
    logic hw_s;
    logic [NCH-1:0] lsel_s, lact_s, tclk_s, tdat_s, rtip_s, rring_s;
    logic [7:0] dlb_q, alb_q, rlb_q, tao_q, auto_all_ones_on_loss_q, gcf_q, cfg_q;
    logic [7:0] actp_q, deap_q, gsel_q, gen_q, imask_q, istat_q;
    logic [7:0] dlb_d, alb_d, rlb_d, tao_d, auto_all_ones_on_loss_d, gcf_d, cfg_d;
    logic [7:0] actp_d, deap_d, gsel_d, gen_d, imask_d, istat_d;
    logic [7:0] rdata_d;
    logic [7:0] div_q, div_d; // bit-rate divider
    logic tick, fifo_rdy;
    logic [NCH-1:0] los, pres_q, chg, auto_rlb, all_ones_transmit_mode_hw;
    logic [NCH-1:0] dlb_e, rlb_e, alb_e, all_ones_transmit_mode_e, tx_src, code_bit;
    logic [NCH-1:0] line_q, rx_line;
    lbc_rx_t rxw; // receive word at this tick
    logic [3:0] alen, dlen;

    // code tracker: returns {match, next phase}
    function automatic logic [3:0] trk(input logic [7:0] p,
        input logic [3:0] len, input logic [2:0] ph, input logic b);
        logic [2:0] nx;
        nx = (ph == 3'(len - 4'h1)) ? 3'h0 : ph + 3'h1;
        if (b == p[3'h7 - ph]) begin
            trk = {1'b1, nx};
        end else begin
            trk = {1'b0, (b == p[7]) ? 3'h1 : 3'h0};
        end
    endfunction

    // two flip-flops on every pin input
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {hw_mode, loop_select_pin, loop_select_act,
                     transmit_clock_in, transmit_data_pos_in,
                     line_rx_tip, line_rx_ring};
            s2_q <= s1_q;
        end
    end
    assign {hw_s, lsel_s, lact_s, tclk_s, tdat_s, rtip_s, rring_s} = s2_q;

    // shared code lengths for all channels
    assign alen = LEN_BASE + {2'b00, cfg_q[CFG_ALEN +: 2]};
    assign dlen = LEN_BASE + {2'b00, cfg_q[CFG_DLEN +: 2]};

    // bit tick from mclk; stalls when the fifo is full
    always_comb begin
        div_d = (div_q == 8'(BIT_DIV - 1)) ? 8'h00 : div_q + 8'h01;
        if (!fifo_rdy && div_q == 8'(BIT_DIV - 1)) begin
            div_d = div_q;
        end
    end
    assign tick = fifo_rdy && (div_q == 8'(BIT_DIV - 1));

    // per-channel datapath and inband code logic
    for (genvar n = 0; n < NCH; n++) begin : g_ch
        logic [4:0] thold_q, thold_d; // tx clock high count
        logic [5:0] zc_q, zc_d; // zero run on watched signal
        logic pol_q, pol_d, lb_d, pr_d, ar_q, ar_d;
        logic [2:0] aph_q, aph_d, dph_q, dph_d, gph_q, gph_d;
        logic [4:0] arun_q, arun_d, drun_q, drun_d;
        logic [31:0] tmr_q, tmr_d; // continuous code time
        lbc_code_t kind_q, kind_d;
        logic [3:0] ta, td;
        logic mon, glen_last;

        // effective modes, straps or registers
        assign rx_line[n] = rtip_s[n] | rring_s[n];
        assign dlb_e[n] = !hw_s && dlb_q[n];
        assign alb_e[n] = hw_s ? (lact_s[n] && lsel_s[n]) : alb_q[n];
        assign rlb_e[n] = (hw_s ? (lact_s[n] && !lsel_s[n]) : rlb_q[n])
                          | ar_q;
        assign all_ones_transmit_mode_hw[n] = hw_s && (thold_q > 5'(ALL_ONES_TRANSMIT_MODE_HOLD_CYC));
        assign all_ones_transmit_mode_e[n] = (hw_s ? all_ones_transmit_mode_hw[n] : tao_q[n])
                           | (auto_all_ones_on_loss_q[n] && los[n]);
        assign code_bit[n] = gsel_q[n] ? deap_q[3'h7 - gph_q]
                                       : actp_q[3'h7 - gph_q];
        assign tx_src[n] = gen_q[n] ? code_bit[n] : tdat_s[n];
        assign mon = alb_e[n] ? line_q[n] : rx_line[n];
        assign los[n] = (zc_q >= 6'(LOS_ZEROS));
        assign auto_rlb[n] = ar_q;
        assign chg[n] = pr_d ^ pres_q[n];
        // receive bit: tx data in digital loop, ais on loss
        assign rxw.receive_data_pos_out[n] = (dlb_e[n] ? tx_src[n] : mon)
            | (los[n] && gcf_q[GCF_ALARM_INSERT_ENABLE]);
        assign rxw.violation_or_neg_out[n] = !dlb_e[n] && !alb_e[n]
            && rtip_s[n] && rring_s[n] && !(los[n] && gcf_q[GCF_ALARM_INSERT_ENABLE]);
        assign glen_last = (gph_q == 3'((gsel_q[n] ? dlen : alen) - 4'h1));

        // next state of the channel
        always_comb begin
            thold_d = tclk_s[n] ? thold_q + 5'(thold_q != 5'h1f) : 5'h00;
            zc_d = zc_q;
            pol_d = pol_q;
            lb_d = line_q[n];
            aph_d = aph_q;
            dph_d = dph_q;
            arun_d = arun_q;
            drun_d = drun_q;
            gph_d = gph_q;
            ta = trk(actp_q, alen, aph_q, rx_line[n]);
            td = trk(deap_q, dlen, dph_q, rx_line[n]);
            if (tick) begin
                zc_d = mon ? 6'h00 : zc_q + 6'(zc_q != 6'h3f);
                // line bit: remote loop, all ones or transmit data
                lb_d = rlb_e[n] ? rx_line[n] : (all_ones_transmit_mode_e[n] | tx_src[n]);
                pol_d = pol_q ^ lb_d;
                gph_d = (!gen_q[n] || glen_last) ? 3'h0 : gph_q + 3'h1;
                aph_d = ta[2:0];
                dph_d = td[2:0];
                arun_d = !ta[3] ? 5'h00 : arun_q + 5'(arun_q != 5'h1f);
                drun_d = !td[3] ? 5'h00 : drun_q + 5'(drun_q != 5'h1f);
            end
            if (!cfg_q[CFG_DET]) begin
                arun_d = 5'h00;
                drun_d = 5'h00;
            end
            // code kind seen now
            if (arun_q >= CODE_MIN_BITS) begin
                kind_d = LBC_ACT;
            end else if (drun_q >= CODE_MIN_BITS) begin
                kind_d = LBC_DEACT;
            end else begin
                kind_d = LBC_NONE;
            end
            pr_d = (kind_d != LBC_NONE);
            tmr_d = (kind_d != kind_q || kind_q == LBC_NONE) ? 32'h0
                    : tmr_q + 32'(tmr_q < LOOP_CYC);
            ar_d = ar_q && cfg_q[CFG_AUTO];
            if (cfg_q[CFG_AUTO] && tmr_q >= LOOP_CYC - 1) begin
                case (kind_q)
                    LBC_ACT: ar_d = 1'b1;
                    LBC_DEACT: ar_d = 1'b0;
                    default: ar_d = ar_q;
                endcase
            end
        end

        // channel state registers
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                thold_q <= 5'h00;
                zc_q <= 6'h00;
                pol_q <= 1'b0;
                line_q[n] <= 1'b0;
                aph_q <= 3'h0;
                dph_q <= 3'h0;
                gph_q <= 3'h0;
                arun_q <= 5'h00;
                drun_q <= 5'h00;
                tmr_q <= 32'h0;
                kind_q <= LBC_NONE;
                ar_q <= 1'b0;
                pres_q[n] <= 1'b0;
                line_tx_tip[n] <= 1'b0;
                line_tx_ring[n] <= 1'b0;
            end else begin
                thold_q <= thold_d;
                zc_q <= zc_d;
                pol_q <= pol_d;
                line_q[n] <= lb_d;
                aph_q <= aph_d;
                dph_q <= dph_d;
                gph_q <= gph_d;
                arun_q <= arun_d;
                drun_q <= drun_d;
                tmr_q <= tmr_d;
                kind_q <= kind_d;
                ar_q <= ar_d;
                pres_q[n] <= pr_d;
                line_tx_tip[n] <= tick ? lb_d && !pol_q : line_tx_tip[n];
                line_tx_ring[n] <= tick ? lb_d && pol_q : line_tx_ring[n];
            end
        end
    end

    // register writes, reads and interrupt latch
    always_comb begin
        {dlb_d, alb_d, rlb_d, tao_d, auto_all_ones_on_loss_d, gcf_d} =
            {dlb_q, alb_q, rlb_q, tao_q, auto_all_ones_on_loss_q, gcf_q};
        {cfg_d, actp_d, deap_d, gsel_d, gen_d, imask_d} =
            {cfg_q, actp_q, deap_q, gsel_q, gen_q, imask_q};
        if (reg_req.wr) begin
            case (reg_req.addr)
                ADR_DLOOP: dlb_d = reg_req.wdata;
                ADR_ALOOP: alb_d = reg_req.wdata;
                ADR_RLOOP: rlb_d = reg_req.wdata;
                ADR_TAO: tao_d = reg_req.wdata;
                ADR_AUTO_ALL_ONES_ON_LOSS: auto_all_ones_on_loss_d = reg_req.wdata;
                ADR_GCF: gcf_d = reg_req.wdata;
                ADR_CFG: cfg_d = reg_req.wdata;
                ADR_ACTP: actp_d = reg_req.wdata;
                ADR_DEAP: deap_d = reg_req.wdata;
                ADR_GSEL: gsel_d = reg_req.wdata;
                ADR_GEN: gen_d = reg_req.wdata;
                ADR_IMASK: imask_d = reg_req.wdata;
                default: ;
            endcase
        end
        // status read clears, a new change in that cycle still sets
        istat_d = (reg_req.rd && reg_req.addr == ADR_STAT) ? 8'h00
                  : istat_q;
        istat_d = istat_d | {4'h0, chg & imask_q[NCH-1:0]};
        case (reg_req.addr)
            ADR_DLOOP: rdata_d = dlb_q;
            ADR_ALOOP: rdata_d = alb_q;
            ADR_RLOOP: rdata_d = rlb_q;
            ADR_TAO: rdata_d = tao_q;
            ADR_AUTO_ALL_ONES_ON_LOSS: rdata_d = auto_all_ones_on_loss_q;
            ADR_GCF: rdata_d = gcf_q;
            ADR_LOSS: rdata_d = {auto_rlb, los};
            ADR_CFG: rdata_d = cfg_q;
            ADR_ACTP: rdata_d = actp_q;
            ADR_DEAP: rdata_d = deap_q;
            ADR_STAT: rdata_d = {4'h0, pres_q};
            ADR_ISTAT: rdata_d = istat_q;
            ADR_IMASK: rdata_d = imask_q;
            ADR_GSEL: rdata_d = gsel_q;
            ADR_GEN: rdata_d = gen_q;
            default: rdata_d = 8'h00;
        endcase
        if (!reg_req.rd) begin
            rdata_d = reg_rdata;
        end
    end

    // register state
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            {dlb_q, alb_q, rlb_q, tao_q, auto_all_ones_on_loss_q, gcf_q} <= {6{REG_RST}};
            {cfg_q, actp_q, deap_q, gsel_q, gen_q} <= {5{REG_RST}};
            imask_q <= REG_RST;
            istat_q <= REG_RST;
            reg_rdata <= REG_RST;
            div_q <= 8'h00;
        end else begin
            {dlb_q, alb_q, rlb_q, tao_q, auto_all_ones_on_loss_q, gcf_q} <=
                {dlb_d, alb_d, rlb_d, tao_d, auto_all_ones_on_loss_d, gcf_d};
            {cfg_q, actp_q, deap_q, gsel_q, gen_q} <=
                {cfg_d, actp_d, deap_d, gsel_d, gen_d};
            imask_q <= imask_d;
            istat_q <= istat_d;
            reg_rdata <= rdata_d;
            div_q <= div_d;
        end
    end
    assign irq_n = !(|istat_q);

    // receive words queue toward the system side
    lbc_fifo #(.W($bits(lbc_rx_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rstn(rstn),
        .in_valid(tick),
        .in_ready(fifo_rdy),
        .in_data(rxw),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // checks on channel 0 and the interrupt latch
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    AST_DLB_ROUTE: assert property (tick && dlb_e[0] && !los[0] |->
        rxw.receive_data_pos_out[0] == tx_src[0]) else $error("dloop");
    AST_AIS: assert property (tick && los[0] && gcf_q[GCF_ALARM_INSERT_ENABLE] |->
        rxw.receive_data_pos_out[0]) else $error("ais missing");
    AST_RLB: assert property (tick && rlb_e[0] |=>
        line_q[0] == $past(rx_line[0])) else $error("rloop");
    AST_AUTO_ALL_ONES_ON_LOSS: assert property (tick && auto_all_ones_on_loss_q[0] && los[0] && !rlb_e[0]
        |=> line_q[0]) else $error("auto all ones");
    AST_ALL_ONES_TRANSMIT_MODE_HW: assert property ($rose(all_ones_transmit_mode_hw[0]) |->
        $past(tclk_s[0], 16) && hw_s) else $error("all_ones_transmit_mode early");
    AST_AUTO_ON: assert property ($rose(auto_rlb[0]) |->
        $past(cfg_q[CFG_AUTO])) else $error("auto loop");
    AST_IRQ: assert property (chg[0] && imask_q[0] |=>
        istat_q[0] && !irq_n) else $error("irq not set");
    AST_MASK: assert property (imask_q == 8'h00 && !(|istat_q) |=>
        !(|istat_q)) else $error("masked irq");
    AST_CLR: assert property (reg_req.rd && reg_req.addr == ADR_STAT
        && chg == '0 |=> istat_q == 8'h00) else $error("clear");
    AST_GEN: assert property (tick && gen_q[0] && !all_ones_transmit_mode_e[0] && !rlb_e[0]
        |=> line_q[0] == $past(code_bit[0])) else $error("gen");
    COV_DUAL: cover property (tick && dlb_e[0] && rlb_e[0]);
    COV_AUTO: cover property ($rose(auto_rlb[0]));
    COV_FULL: cover property (!fifo_rdy);
endmodule

`default_nettype wire

/* File: tb/lbc_line_far.sv */
// far-end line equipment model driving the receive rails
`timescale 1ns/10ps
`default_nettype none
module lbc_line_far #(
    parameter int BIT_DIV = 4
) (
    // clock
    input wire logic mclk,
    // traffic: 0 zeros, 1 all ones, 2 repeating code
    input wire logic [1:0] mode,
    input wire logic [7:0] pat,
    input wire logic [3:0] len,
    // rails toward the device
    output logic [3:0] tip,
    output logic [3:0] ring
);
    int div = 0; // cycles inside one bit
    int ph = 0; // bit position in the code
    logic pol = 1'b0; // polarity of the next mark
    logic b; // bit on the line
    // one bit each BIT_DIV cycles, marks alternate rails
    always @(posedge mclk) begin
        div = (div + 1) % BIT_DIV;
        if (div == 0) begin
            b = (mode == 2'h1) || (mode == 2'h2 && pat[7 - ph]);
            ph = (ph + 1 >= int'(len)) ? 0 : ph + 1;
            tip <= {4{b & ~pol}};
            ring <= {4{b & pol}};
            if (b) pol = ~pol;
        end
    end
endmodule
`default_nettype wire

/* File: tb/lbc_top_test.sv */
// self-checking bench for the loopback and inband code block
`timescale 1ns/10ps
`default_nettype none
module lbc_top_test;
    import lbc_pkg::*;
    localparam int BD = 4; // short bit period
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    lbc_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic hw_mode = 1'b0;
    logic [3:0] loop_select_pin = 4'h0;
    logic [3:0] loop_select_act = 4'h0;
    logic [3:0] transmit_clock_in = 4'h0;
    logic [3:0] transmit_data_pos_in = 4'h0;
    logic [3:0] line_rx_tip, line_rx_ring, line_tx_tip, line_tx_ring;
    lbc_rx_t rx_data;
    logic rx_valid, irq_n;
    logic rx_ready = 1'b1;
    logic tclk_hold = 1'b0; // hold tx clock high
    logic [1:0] mode = 2'h0; // far-end traffic
    logic [7:0] pat = 8'h00;
    logic [3:0] len = 4'h5;
    int bad_count = 0;
    int tests_run = 0;
    // device and far end
    lbc_top #(.BIT_DIV(BD), .LOOP_CYC(200), .FIFO_DEPTH(16)) lbc_top_i (
        .mclk(mclk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .hw_mode(hw_mode), .loop_select_pin(loop_select_pin),
        .loop_select_act(loop_select_act),
        .transmit_clock_in(transmit_clock_in),
        .transmit_data_pos_in(transmit_data_pos_in),
        .line_rx_tip(line_rx_tip), .line_rx_ring(line_rx_ring),
        .line_tx_tip(line_tx_tip), .line_tx_ring(line_tx_ring),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .irq_n(irq_n));
    lbc_line_far #(.BIT_DIV(BD)) lbc_line_far_i (.mclk(mclk), .mode(mode),
        .pat(pat), .len(len), .tip(line_rx_tip), .ring(line_rx_ring));
    // 25 mhz clock
    always #20 mclk = ~mclk;
    // toggling tx clock unless held
    always @(negedge mclk)
        transmit_clock_in <= tclk_hold ? 4'hf : ~transmit_clock_in;
    task automatic finish_test;
        if (bad_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // register write, one-cycle strobe
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_req = '{1'b1, 1'b0, a, d};
        @(negedge mclk);
        reg_req.wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge mclk);
        reg_req.rd = 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    // poll a register field under a bounded count
    task automatic pollr(input logic [4:0] a, input logic [7:0] m, e);
        logic [7:0] d;
        int i;
        i = 0;
        d = ~e;
        while ((d & m) !== e && i < 300) begin
            rd(a, d);
            i++;
        end
        chk(d & m, e);
        if ((d & m) !== e) finish_test();
    endtask
    // settle, then check the receive data of the next word
    task automatic rxc(input logic [3:0] e);
        int i;
        cyc(160);
        i = 0;
        while (rx_valid !== 1'b1 && i < 50) begin
            cyc(1);
            i++;
        end
        if (i == 50) begin
            bad_count++;
            finish_test();
        end
        chk({4'h0, rx_data.receive_data_pos_out}, {4'h0, e});
    endtask
    // settle, then count line marks per channel over n bits
    task automatic txm(input int n, input logic [31:0] e);
        logic [7:0] c [4];
        for (int k = 0; k < 4; k++) c[k] = 8'h00;
        cyc(160);
        repeat (n) begin
            for (int k = 0; k < 4; k++)
                c[k] = c[k] + {7'h0, line_tx_tip[k] | line_tx_ring[k]};
            cyc(BD);
        end
        for (int k = 0; k < 4; k++) chk(c[k], e[8*k +: 8]);
    endtask
    // marks in eight periods of a left-aligned code
    function automatic logic [7:0] exp_marks(input logic [7:0] p, input int l);
        exp_marks = 8'h00;
        for (int k = 0; k < l; k++) exp_marks = exp_marks + {7'h0, p[7-k]};
        exp_marks = exp_marks * 8'h08;
    endfunction
    localparam logic [31:0] ALL = {4{8'h28}}; // 40 marks each
    initial begin
        logic [7:0] pa, pd, d;
        logic f;
        void'($urandom(2761));
        cyc(8);
        rstn = 1'b1;
        chk({7'h0, irq_n}, 8'h01);
        rdc(ADR_CFG, REG_RST);
        rdc(ADR_GEN, REG_RST);
        rdc(ADR_IMASK, REG_RST);
        for (int a = 8; a < 16; a++) if (a != 11 && a != 12 && a != 13) begin
            pa = 8'($urandom);
            wr(5'(a), pa);
            rdc(5'(a), pa);
            wr(5'(a), 8'h00);
        end
        wr(5'h1f, 8'hff);
        rdc(5'h1f, 8'h00);
        wr(ADR_STAT, 8'hff);
        rdc(ADR_STAT, 8'h00);
        transmit_data_pos_in = 4'hf;
        rxc(4'h0);
        wr(ADR_DLOOP, 8'h0f);
        rxc(4'hf);
        txm(40, ALL);
        wr(ADR_DLOOP, 8'h00);
        wr(ADR_ALOOP, 8'h0f);
        rxc(4'hf);
        wr(ADR_ALOOP, 8'h00);
        transmit_data_pos_in = 4'h0;
        mode = 2'h1;
        wr(ADR_RLOOP, 8'h0f);
        rxc(4'hf);
        txm(40, ALL);
        wr(ADR_DLOOP, 8'h0f);
        rxc(4'h0);
        txm(40, ALL);
        wr(ADR_DLOOP, 8'h00);
        wr(ADR_RLOOP, 8'h00);
        hw_mode = 1'b1;
        loop_select_act = 4'hf;
        loop_select_pin = 4'h0;
        txm(40, ALL);
        mode = 2'h0;
        transmit_data_pos_in = 4'hf;
        loop_select_pin = 4'hf;
        rxc(4'hf);
        transmit_data_pos_in = 4'h0;
        loop_select_act = 4'h0;
        tclk_hold = 1'b1;
        txm(40, ALL);
        tclk_hold = 1'b0;
        txm(40, 32'h0);
        hw_mode = 1'b0;
        wr(ADR_TAO, 8'h0f);
        txm(40, ALL);
        wr(ADR_TAO, 8'h00);
        wr(ADR_DLOOP, 8'h0f);
        wr(ADR_GCF, 8'h01);
        wr(ADR_AUTO_ALL_ONES_ON_LOSS, 8'h0f);
        rxc(4'hf);
        txm(40, ALL);
        rdc(ADR_LOSS, 8'h0f);
        wr(ADR_DLOOP, 8'h00);
        wr(ADR_GCF, 8'h00);
        wr(ADR_AUTO_ALL_ONES_ON_LOSS, 8'h00);
        for (int k = 0; k < 8; k++) begin
            pa = 8'($urandom);
            pd = 8'($urandom);
            wr(ADR_ACTP, pa);
            wr(ADR_DEAP, pd);
            wr(ADR_CFG, {2'h0, 2'(k), 2'(k), 2'h0});
            wr(ADR_GSEL, {6'h0, k[2], 1'b0});
            wr(ADR_GEN, 8'h02);
            txm(8 * (5 + k % 4),
                {16'h0, exp_marks(k[2] ? pd : pa, 5 + k % 4), 8'h0});
        end
        rx_ready = 1'b0;
        cyc(120);
        d = {4'h0, line_tx_tip};
        f = 1'b0;
        repeat (40) begin
            cyc(1);
            f = f | ({4'h0, line_tx_tip} !== d);
        end
        chk({7'h0, f}, 8'h00);
        rx_ready = 1'b1;
        repeat (16) begin
            chk({7'h0, rx_valid}, 8'h01);
            cyc(1);
        end
        rdc(ADR_GEN, 8'h02);
        f = 1'b0;
        repeat (20) begin
            cyc(1);
            f = f | ~rx_valid;
        end
        chk({7'h0, f}, 8'h01);
        wr(ADR_GEN, 8'h00);
        mode = 2'h2;
        pat = 8'hc6;
        wr(ADR_ACTP, 8'hc6);
        wr(ADR_DEAP, 8'he7);
        wr(ADR_IMASK, 8'h00);
        wr(ADR_CFG, 8'h01);
        pollr(ADR_STAT, 8'h0f, 8'h0f);
        rdc(ADR_ISTAT, 8'h00);
        chk({7'h0, irq_n}, 8'h01);
        cyc(400);
        rdc(ADR_LOSS, 8'h00);
        wr(ADR_CFG, 8'h00);
        cyc(200);
        wr(ADR_IMASK, 8'h0f);
        wr(ADR_CFG, 8'h03);
        pollr(ADR_ISTAT, 8'h0f, 8'h0f);
        chk({7'h0, irq_n}, 8'h00);
        rdc(ADR_ISTAT, 8'h0f);
        rdc(ADR_STAT, 8'h0f);
        rdc(ADR_ISTAT, 8'h00);
        chk({7'h0, irq_n}, 8'h01);
        pollr(ADR_LOSS, 8'hf0, 8'hf0);
        txm(40, {4{8'h10}});
        pat = 8'he7;
        pollr(ADR_LOSS, 8'hf0, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
